// ===== bdlb_pkg.sv
package bdlb_pkg;

    // ------------------------------------------------------------
    // Operand widths and constants
    // ------------------------------------------------------------
    localparam int         BYTE_W       = 8;
    localparam int         PC_W         = 16;
    localparam logic [7:0] BYTE_ZERO    = 8'h00;
    localparam logic [7:0] BYTE_ONE     = 8'h01;
    localparam logic [7:0] ESCAPE_BYTE  = 8'hA5;
    localparam logic [3:0] DIV_STEPS    = 4'h8;
    localparam logic [3:0] STEP_ZERO    = 4'h0;

    // ------------------------------------------------------------
    // Operation select and sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        BDLB_OP_NONE,
        BDLB_OP_DIVIDE,
        BDLB_OP_LOOP
    } bdlb_op_t;

    typedef enum logic [1:0]
    {
        BDLB_IDLE,
        BDLB_DIV_RUN,
        BDLB_DONE
    } bdlb_state_t;

endpackage

// ===== bdlb_exec.sv
`timescale 1ns/1ps
// Contract
// RL1 - Divide treats A and B unsigned; quotient to A, remainder to B.
// RL2 - Divisor zero: carry cleared, overflow set, A and B undefined.
// RL3 - Nonzero divisor: divide ends with carry and overflow cleared.
// RL4 - Loop op decrements target, stores it, branches only if result nonzero.
// RL5 - Target 00H wraps to 0FFH and the branch is taken.
// RL6 - Branch target is next-instruction PC plus sign-extended displacement.
// RL7 - Loop target is a working byte register or a direct byte location.
// RL8 - Port targets take the original value from the output latch, not pins.
// RL9 - Register form needs escape byte A5 in source mode, none in binary.
module bdlb_exec
(
    input  wire logic                       ref_clk_in,
    input  wire logic                       reset_in,
    input  wire logic                       start_in,
    input  wire bdlb_pkg::bdlb_op_t         op_in,
    input  wire logic [bdlb_pkg::BYTE_W-1:0] acc_in,
    input  wire logic [bdlb_pkg::BYTE_W-1:0] reg_b_in,
    input  wire logic                       target_is_direct_in,
    input  wire logic [bdlb_pkg::BYTE_W-1:0] working_byte_register_in,
    input  wire logic [bdlb_pkg::BYTE_W-1:0] direct_byte_location_in,
    input  wire logic                       target_is_port_in,
    input  wire logic [bdlb_pkg::BYTE_W-1:0] port_latch_in,
    input  wire logic [bdlb_pkg::PC_W-1:0]   next_pc_in,
    input  wire logic [bdlb_pkg::BYTE_W-1:0] displacement_in,
    input  wire logic                       source_mode_in,
    input  wire logic                       escape_seen_in,
    input  wire logic [bdlb_pkg::BYTE_W-1:0] escape_byte_in,
    output logic                            busy_out,
    output logic                            done_out,
    output logic                            illegal_out,
    output logic [bdlb_pkg::BYTE_W-1:0]      acc_out,
    output logic [bdlb_pkg::BYTE_W-1:0]      reg_b_out,
    output logic                            carry_flag_out,
    output logic                            overflow_flag_out,
    output logic                            write_acc_b_out,
    output logic [bdlb_pkg::BYTE_W-1:0]      target_out,
    output logic                            write_target_out,
    output logic                            write_direct_out,
    output logic                            branch_taken_out,
    output logic [bdlb_pkg::PC_W-1:0]        branch_pc_out
);
    import bdlb_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [BYTE_W-1:0] dec_byte(input logic [BYTE_W-1:0] v);
        dec_byte = v - BYTE_ONE;
    endfunction

    function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc, input logic [BYTE_W-1:0] d);
        rel_target = pc + {{(PC_W-BYTE_W){d[BYTE_W-1]}}, d};
    endfunction

    bdlb_state_t       state_q;
    logic [3:0]        step_q;
    logic [BYTE_W-1:0] quot_q;
    logic [BYTE_W:0]   rem_q;
    logic [BYTE_W-1:0] divisor_q;
    logic [BYTE_W-1:0] orig_byte;
    logic [BYTE_W-1:0] dec_val;
    logic [BYTE_W:0]   trial;
    logic              esc_ok;

    // ------------------------------------------------------------
    // Operand selection
    // ------------------------------------------------------------
    always_comb
    begin
        if (target_is_port_in)
            orig_byte = port_latch_in;                           // see RL8
        else if (target_is_direct_in)
            orig_byte = direct_byte_location_in;                 // see RL7
        else
            orig_byte = working_byte_register_in;                // see RL7
        dec_val = dec_byte(orig_byte);                           // see RL4
        // Register form in source mode is legal only behind the escape byte.
        esc_ok = target_is_direct_in || !source_mode_in ||
                 (escape_seen_in && escape_byte_in == ESCAPE_BYTE); // see RL9
        trial = {rem_q[BYTE_W-1:0], quot_q[BYTE_W-1]} - {1'b0, divisor_q};
    end

    // ------------------------------------------------------------
    // Sequencer and restoring divider
    // ------------------------------------------------------------
    // One quotient bit per clock keeps the datapath to a single subtractor.
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            state_q   <= BDLB_IDLE;
            step_q    <= STEP_ZERO;
            quot_q    <= BYTE_ZERO;
            rem_q     <= '0;
            divisor_q <= BYTE_ZERO;
        end
        else
        begin
            case (state_q)
                BDLB_IDLE:
                begin
                    if (start_in && op_in == BDLB_OP_DIVIDE)
                    begin
                        quot_q    <= acc_in;                     // see RL1
                        rem_q     <= '0;
                        divisor_q <= reg_b_in;
                        step_q    <= STEP_ZERO;
                        state_q   <= (reg_b_in == BYTE_ZERO) ? BDLB_DONE : BDLB_DIV_RUN;
                    end
                end
                BDLB_DIV_RUN:
                begin
                    if (!trial[BYTE_W])
                    begin
                        rem_q  <= trial;
                        quot_q <= {quot_q[BYTE_W-2:0], 1'b1};
                    end
                    else
                    begin
                        rem_q  <= {rem_q[BYTE_W-1:0], quot_q[BYTE_W-1]};
                        quot_q <= {quot_q[BYTE_W-2:0], 1'b0};
                    end
                    step_q <= step_q + 4'h1;
                    if (step_q == DIV_STEPS - 4'h1)
                        state_q <= BDLB_DONE;
                end
                BDLB_DONE:
                    state_q <= BDLB_IDLE;
                default:
                    state_q <= BDLB_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Divide results
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            acc_out           <= BYTE_ZERO;
            reg_b_out         <= BYTE_ZERO;
            carry_flag_out    <= 1'b0;
            overflow_flag_out <= 1'b0;
            write_acc_b_out   <= 1'b0;
        end
        else
        begin
            write_acc_b_out <= (state_q == BDLB_DONE);
            if (state_q == BDLB_DONE)
            begin
                // Zero divisor passes A through untouched and returns zero in B; their value is undefined anyway.
                acc_out           <= quot_q;                     // see RL1
                reg_b_out         <= rem_q[BYTE_W-1:0];          // see RL1
                carry_flag_out    <= 1'b0;                       // see RL2, RL3
                overflow_flag_out <= (divisor_q == BYTE_ZERO);   // see RL2, RL3
            end
        end
    end

    // ------------------------------------------------------------
    // Decrement and branch
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            target_out       <= BYTE_ZERO;
            write_target_out <= 1'b0;
            write_direct_out <= 1'b0;
            branch_taken_out <= 1'b0;
            branch_pc_out    <= '0;
            illegal_out      <= 1'b0;
        end
        else
        begin
            write_target_out <= 1'b0;
            branch_taken_out <= 1'b0;
            illegal_out      <= 1'b0;
            if (state_q == BDLB_IDLE && start_in && op_in == BDLB_OP_LOOP)
            begin
                if (esc_ok)
                begin
                    target_out       <= dec_val;                 // see RL4, RL5
                    write_target_out <= 1'b1;
                    write_direct_out <= target_is_direct_in;     // see RL7
                    branch_taken_out <= (dec_val != BYTE_ZERO);  // see RL4, RL5
                    branch_pc_out    <= (dec_val != BYTE_ZERO) ?
                                        rel_target(next_pc_in, displacement_in) : next_pc_in; // see RL6
                end
                else
                    illegal_out <= 1'b1;                         // see RL9
            end
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end
        else
        begin
            busy_out <= (state_q == BDLB_IDLE) ? (start_in && op_in == BDLB_OP_DIVIDE) : (state_q == BDLB_DIV_RUN);
            done_out <= (state_q == BDLB_DONE) ||
                        (state_q == BDLB_IDLE && start_in && op_in == BDLB_OP_LOOP);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_div_zero_flags: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL2
        (state_q == BDLB_IDLE && start_in && op_in == BDLB_OP_DIVIDE && reg_b_in == BYTE_ZERO)
        |-> ##2 (write_acc_b_out && overflow_flag_out && !carry_flag_out))
        else $error("Zero divisor did not set overflow and clear carry.");

    a_div_result: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL1
        (state_q == BDLB_IDLE && start_in && op_in == BDLB_OP_DIVIDE && reg_b_in != BYTE_ZERO)
        |-> ##10 (write_acc_b_out && acc_out == $past(acc_in, 10) / $past(reg_b_in, 10)
                  && reg_b_out == $past(acc_in, 10) % $past(reg_b_in, 10)))
        else $error("Divide quotient or remainder wrong.");

    a_div_flags_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL3
        (write_acc_b_out && $past(divisor_q) != BYTE_ZERO) |-> !carry_flag_out && !overflow_flag_out)
        else $error("Nonzero divide left a flag set.");

    a_loop_decrement: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL4
        (state_q == BDLB_IDLE && start_in && op_in == BDLB_OP_LOOP && esc_ok)
        |=> write_target_out && target_out == $past(orig_byte) - BYTE_ONE
            && branch_taken_out == (target_out != BYTE_ZERO))
        else $error("Loop decrement or branch decision wrong.");

    a_loop_wrap: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL5
        (state_q == BDLB_IDLE && start_in && op_in == BDLB_OP_LOOP && esc_ok && orig_byte == BYTE_ZERO)
        |=> target_out == 8'hFF && branch_taken_out)
        else $error("Zero target did not wrap and branch.");

    a_branch_pc: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL6
        branch_taken_out |-> branch_pc_out ==
            $past(next_pc_in) + {{8{$past(displacement_in[7])}}, $past(displacement_in)})
        else $error("Branch target miscomputed.");

    a_port_latch: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL8
        (state_q == BDLB_IDLE && start_in && op_in == BDLB_OP_LOOP && esc_ok && target_is_port_in)
        |=> target_out == $past(port_latch_in) - BYTE_ONE)
        else $error("Port target not read from output latch.");

    a_target_select: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL7
        (start_in && op_in == BDLB_OP_LOOP && state_q == BDLB_IDLE && esc_ok)
        |=> write_direct_out == $past(target_is_direct_in))
        else $error("Direct target select not reported.");

    a_escape_rule: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL9
        (state_q == BDLB_IDLE && start_in && op_in == BDLB_OP_LOOP && !target_is_direct_in
         && source_mode_in && !escape_seen_in)
        |=> illegal_out && !write_target_out)
        else $error("Unprefixed register form accepted in source mode.");

endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
    import bdlb_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic            ref_clk_in, reset_in, start_in, target_is_direct_in, target_is_port_in;
    logic            source_mode_in, escape_seen_in;
    bdlb_op_t        op_in;
    logic [7:0]      acc_in, reg_b_in, working_byte_register_in, direct_byte_location_in;
    logic [7:0]      port_latch_in, displacement_in, escape_byte_in;
    logic [15:0]     next_pc_in;
    logic            busy_out, done_out, illegal_out, carry_flag_out, overflow_flag_out;
    logic            write_acc_b_out, write_target_out, write_direct_out, branch_taken_out;
    logic [7:0]      acc_out, reg_b_out, target_out;
    logic [15:0]     branch_pc_out;
    int              err_total, checks;
    logic [31:0]     seed;
    int              divs[$] = '{0, 1, 255, 18};

    bdlb_exec i_bdlb_exec
    (
        .ref_clk_in, .reset_in, .start_in, .op_in, .acc_in, .reg_b_in, .target_is_direct_in,
        .working_byte_register_in, .direct_byte_location_in, .target_is_port_in, .port_latch_in,
        .next_pc_in, .displacement_in, .source_mode_in, .escape_seen_in, .escape_byte_in,
        .busy_out, .done_out, .illegal_out, .acc_out, .reg_b_out, .carry_flag_out, .overflow_flag_out,
        .write_acc_b_out, .target_out, .write_target_out, .write_direct_out, .branch_taken_out,
        .branch_pc_out
    );

    initial
    begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // A second start while the divide runs must be ignored, so the latency must not shrink.
    task automatic run_div(input logic [7:0] a, input logic [7:0] b, input logic poke);
        int n;
        int lat;
        lat = (b == 0) ? 2 : 10;
        @(posedge ref_clk_in);
        op_in    <= BDLB_OP_DIVIDE;
        acc_in   <= a;
        reg_b_in <= b;
        start_in <= 1'b1;
        @(posedge ref_clk_in);
        op_in    <= BDLB_OP_LOOP;
        start_in <= poke;
        n = 1;
        #1;
        chk(busy_out === 1'b1, "busy after accept");
        while (done_out !== 1'b1 && n < 16)
        begin
            @(posedge ref_clk_in);
            start_in <= 1'b0;
            #1;
            n++;
        end
        if (n >= 16)
        begin
            chk(1'b0, "divide never completed");
            final_report();
        end
        chk(n == lat && write_acc_b_out === 1'b1 && busy_out === 1'b0, "divide latency");
        if (b != 0)
        begin
            chk(acc_out === 8'(int'(a) / int'(b)), "quotient");
            chk(reg_b_out === 8'(int'(a) % int'(b)), "remainder");
            chk(carry_flag_out === 1'b0 && overflow_flag_out === 1'b0, "flags nonzero divisor");
        end
        else
            chk(carry_flag_out === 1'b0 && overflow_flag_out === 1'b1, "flags zero divisor");
    endtask

    task automatic run_loop(input logic [7:0] orig);
        logic [31:0] r;
        logic [31:0] s;
        logic        ill;
        logic        tk;
        logic [7:0]  res;
        logic [15:0] epc;
        r = xs();
        s = xs();
        @(posedge ref_clk_in);
        op_in                    <= BDLB_OP_LOOP;
        target_is_direct_in      <= r[0];
        target_is_port_in        <= r[0] & r[1];
        source_mode_in           <= r[2];
        escape_seen_in           <= r[3];
        escape_byte_in           <= r[4] ? ESCAPE_BYTE : s[7:0];
        working_byte_register_in <= r[0] ? s[15:8] : orig;
        direct_byte_location_in  <= (r[0] & ~r[1]) ? orig : s[23:16];
        port_latch_in            <= (r[0] & r[1]) ? orig : s[31:24];
        displacement_in          <= r[15:8];
        next_pc_in               <= r[31:16];
        start_in                 <= 1'b1;
        @(posedge ref_clk_in);
        start_in <= 1'b0;
        ill = !r[0] && r[2] && !(r[3] && (r[4] || s[7:0] == ESCAPE_BYTE));
        res = orig - 8'h01;
        tk  = (res != 8'h00);
        epc = r[31:16] + {{8{r[15]}}, r[15:8]};
        #1;
        chk(done_out === 1'b1, "loop done");
        if (ill)
            chk(illegal_out === 1'b1 && write_target_out === 1'b0, "missing escape prefix");
        else
        begin
            chk(illegal_out === 1'b0 && write_target_out === 1'b1, "prefix accepted");
            chk(target_out === res, "decremented byte");
            chk(write_direct_out === r[0], "target kind");
            chk(branch_taken_out === tk, "branch decision");
            chk(branch_pc_out === (tk ? epc : r[31:16]), "branch address");
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {start_in, target_is_direct_in, target_is_port_in, source_mode_in, escape_seen_in} = 5'h00;
        {acc_in, reg_b_in, working_byte_register_in, direct_byte_location_in} = 32'h0000_0000;
        {port_latch_in, displacement_in, escape_byte_in, next_pc_in} = 40'h00_0000_0000;
        op_in     = BDLB_OP_NONE;
        reset_in  = 1'b1;
        err_total = 0;
        checks    = 0;
        seed      = 32'h09E1D6AC;
        repeat (20) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        #1;
        chk(done_out === 1'b0 && busy_out === 1'b0, "outputs idle after reset");
        run_div(8'hFB, 8'h12, 1'b0);
        foreach (divs[i])
            run_div(8'(xs()), divs[i][7:0], 1'b0);
        for (int i = 0; i < 40; i++)
            run_div(8'(xs()), (i % 5 == 0) ? 8'h00 : 8'(xs()), i[1]);
        $display("divide test done");
        for (int i = 0; i < 4; i++)
        begin
            run_loop(8'h00);
            run_loop(8'h01);
            run_loop(8'hFF);
        end
        for (int i = 0; i < 80; i++)
            run_loop(8'(xs()));
        $display("loop test done");
        final_report();
    end
endmodule
